/* File: apso_top.sv */
`timescale 1ns/100ps
`default_nettype none
`include "apso_regs.svh"

// ----------------------------------------------------------------
// character fifo
// ----------------------------------------------------------------
module apso_fifo #(
  parameter int WIDTH = `APSO_CHAR_W,
  parameter int DEPTH = `APSO_FIFO_DEPTH
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic resetn_i,
  // write side
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  // read side
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_ff [DEPTH];
  logic [AW:0] wr_ff, nxt_wr, rd_ff, nxt_rd;
  logic full, empty, push, pop;

  assign full = (wr_ff[AW-1:0] == rd_ff[AW-1:0]) && (wr_ff[AW] != rd_ff[AW]);
  assign empty = (wr_ff == rd_ff);
  assign in_ready_o = !full;
  assign out_valid_o = !empty;
  assign out_data_o = mem_ff[rd_ff[AW-1:0]];
  assign push = in_valid_i && !full;
  assign pop = out_ready_i && !empty;

  always_comb begin
    nxt_wr = push ? wr_ff + 1'b1 : wr_ff;
    nxt_rd = pop ? rd_ff + 1'b1 : rd_ff;
  end

  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      wr_ff <= '0;
      rd_ff <= '0;
    end else begin
      wr_ff <= nxt_wr;
      rd_ff <= nxt_rd;
    end
  end

  // storage needs no reset; empty flag guards stale words
  always_ff @(posedge clk_i) begin
    if (push) begin
      mem_ff[wr_ff[AW-1:0]] <= in_data_i;
    end
  end
endmodule : apso_fifo

// ----------------------------------------------------------------
// absolute position serial output
// ----------------------------------------------------------------
module apso_top
  import apso_pkg::*;
#(
  parameter int BIT_CYC_P = `APSO_BIT_CYC,
  parameter int REQ_WAIT_P = `APSO_REQ_WAIT_CYC,
  parameter int NORM_WAIT_P = `APSO_NORM_WAIT_CYC,
  parameter int ENC_RES_P = `APSO_ENC_RES
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic resetn_i,
  // host request
  input wire logic absolute_data_request_i,
  // encoder events
  input wire logic enc_step_i,
  input wire logic enc_fwd_i,
  input wire logic rev_step_i,
  input wire logic rev_fwd_i,
  input wire logic [17:0] init_pulse_count_i,
  // configuration
  input wire logic absolute_encoder_i,
  input wire logic single_turn_i,
  input wire logic [17:0] output_pulse_divider_setting_i,
  input wire logic [15:0] multiturn_limit_setting_i,
  input wire logic [15:0] encoder_multiturn_limit_i,
  // alarm source
  input wire logic alarm_active_i,
  input wire logic [11:0] alarm_code_i,
  // pins and status
  output logic phase_a_output_o,
  output logic phase_b_output_o,
  output logic multiturn_limit_mismatch_alarm_o,
  output logic serial_active_o,
  output logic [15:0] revolution_count_o
);
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [16:0] pow10(input logic [2:0] idx);
    case (idx)
      3'h0: pow10 = `APSO_POW0;
      3'h1: pow10 = `APSO_POW1;
      3'h2: pow10 = `APSO_POW2;
      3'h3: pow10 = `APSO_POW3;
      default: pow10 = `APSO_POW4;
    endcase
  endfunction : pow10

  function automatic logic [6:0] hex_char(input logic [3:0] nib);
    hex_char = (nib < 4'hA) ? (`APSO_CH_ZERO + {3'h0, nib}) : (`APSO_CH_HEXA + {3'h0, nib});
  endfunction : hex_char

  function automatic logic [6:0] alm_char(input logic [2:0] idx, input logic [11:0] code);
    case (idx)
      3'h0: alm_char = `APSO_CH_A;
      3'h1: alm_char = `APSO_CH_L;
      3'h2: alm_char = `APSO_CH_M;
      3'h3: alm_char = hex_char(code[11:8]);
      3'h4: alm_char = hex_char(code[7:4]);
      3'h5: alm_char = hex_char(code[3:0]);
      default: alm_char = `APSO_CH_CR;
    endcase
  endfunction : alm_char

  // ----------------------------------------------------------------
  // multiturn limit, captured once after reset
  // ----------------------------------------------------------------
  logic cfg_done_ff, nxt_cfg_done;
  logic [15:0] limit_ff, nxt_limit;
  logic nxt_alarm;
  logic is_default;

  assign is_default = (limit_ff == `APSO_LIMIT_DEFAULT);

  always_comb begin
    nxt_cfg_done = 1'b1;
    nxt_limit = limit_ff;
    if (!cfg_done_ff) begin
      nxt_limit = absolute_encoder_i ? multiturn_limit_setting_i : `APSO_LIMIT_DEFAULT;
    end
    nxt_alarm = cfg_done_ff && absolute_encoder_i && (limit_ff != encoder_multiturn_limit_i);
  end

  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      cfg_done_ff <= 1'b0;
      limit_ff <= `APSO_LIMIT_DEFAULT;
    end else begin
      cfg_done_ff <= nxt_cfg_done;
      limit_ff <= nxt_limit;
    end
  end

  // ----------------------------------------------------------------
  // revolution counter
  // ----------------------------------------------------------------
  logic [15:0] rev_ff, nxt_rev;

  always_comb begin
    nxt_rev = rev_ff;
    if (single_turn_i) begin
      nxt_rev = 16'h0000;
    end else if (rev_step_i && cfg_done_ff) begin
      if (is_default) begin
        // two's complement wrap gives +32767 <-> -32768
        nxt_rev = rev_fwd_i ? rev_ff + 16'h0001 : rev_ff - 16'h0001;
      end else if (rev_fwd_i) begin
        nxt_rev = (rev_ff == limit_ff) ? 16'h0000 : rev_ff + 16'h0001;
      end else begin
        nxt_rev = (rev_ff == 16'h0000) ? limit_ff : rev_ff - 16'h0001;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      rev_ff <= 16'h0000;
    end else begin
      rev_ff <= nxt_rev;
    end
  end

  // ----------------------------------------------------------------
  // sequencer and message builder
  // ----------------------------------------------------------------
  apso_state_e st_ff, nxt_st;
  logic [24:0] tmr_ff, nxt_tmr;
  logic [16:0] mag_ff, nxt_mag;
  logic [3:0] dig_ff, nxt_dig;
  logic [2:0] idx_ff, nxt_idx;
  logic neg_ff, nxt_neg;
  logic [17:0] init_left_ff, nxt_init_left;
  logic req_d_ff;
  logic clr_pulse;
  logic push_valid;
  logic [6:0] push_data;
  logic fifo_in_ready, fifo_out_valid, tx_busy_ff, nco_tick;
  logic [6:0] fifo_out_data;

  always_comb begin
    nxt_st = st_ff;
    nxt_tmr = tmr_ff;
    nxt_mag = mag_ff;
    nxt_dig = dig_ff;
    nxt_idx = idx_ff;
    nxt_neg = neg_ff;
    nxt_init_left = init_left_ff;
    clr_pulse = 1'b0;
    push_valid = 1'b0;
    push_data = `APSO_CH_CR;
    case (st_ff)
      ST_IDLE: begin
        if (absolute_data_request_i && !req_d_ff) begin
          nxt_st = ST_WAIT;
          nxt_tmr = '0;
        end
      end
      ST_WAIT: begin
        nxt_tmr = tmr_ff + 25'h0000001;
        if (tmr_ff >= 25'(REQ_WAIT_P - 1)) begin
          clr_pulse = 1'b1;
          nxt_neg = is_default && rev_ff[15];
          nxt_mag = (is_default && rev_ff[15]) ? {1'b0, 16'h0000 - rev_ff} : {1'b0, rev_ff};
          nxt_init_left = init_pulse_count_i;
          nxt_st = ST_HEAD;
        end
      end
      ST_HEAD: begin
        push_valid = 1'b1;
        push_data = `APSO_CH_P;
        if (fifo_in_ready) begin
          nxt_st = ST_SIGN;
        end
      end
      ST_SIGN: begin
        push_valid = 1'b1;
        // zero is sent with a plus sign
        push_data = neg_ff ? `APSO_CH_MINUS : `APSO_CH_PLUS;
        if (fifo_in_ready) begin
          nxt_st = ST_DIGIT;
          nxt_idx = 3'h0;
          nxt_dig = 4'h0;
        end
      end
      ST_DIGIT: begin
        // repeated subtraction, one step per clock, avoids a divider
        if (mag_ff >= pow10(idx_ff)) begin
          nxt_mag = mag_ff - pow10(idx_ff);
          nxt_dig = dig_ff + 4'h1;
        end else begin
          push_valid = 1'b1;
          push_data = `APSO_CH_ZERO + {3'h0, dig_ff};
          if (fifo_in_ready) begin
            nxt_dig = 4'h0;
            nxt_idx = idx_ff + 3'h1;
            if (idx_ff == `APSO_MSG_DIGITS - 3'h1) begin
              nxt_st = ST_CR;
            end
          end
        end
      end
      ST_CR: begin
        push_valid = 1'b1;
        push_data = `APSO_CH_CR;
        if (fifo_in_ready) begin
          nxt_st = ST_DRAIN;
        end
      end
      ST_DRAIN: begin
        nxt_tmr = '0;
        if (!fifo_out_valid && !tx_busy_ff) begin
          nxt_st = ST_INIT;
        end
      end
      ST_INIT: begin
        nxt_tmr = tmr_ff + 25'h0000001;
        if (nco_tick && (init_left_ff != 18'h00000)) begin
          nxt_init_left = init_left_ff - 18'h00001;
        end
        if ((tmr_ff >= 25'(NORM_WAIT_P - 1)) && (init_left_ff == 18'h00000)) begin
          nxt_st = ST_NORM;
        end
      end
      ST_ALARM: begin
        push_valid = 1'b1;
        push_data = alm_char(idx_ff, alarm_code_i);
        if (fifo_in_ready) begin
          nxt_idx = idx_ff + 3'h1;
          if (idx_ff == `APSO_ALM_CHARS - 3'h1) begin
            nxt_st = ST_ADRAIN;
          end
        end
      end
      ST_ADRAIN: begin
        if (!fifo_out_valid && !tx_busy_ff) begin
          nxt_st = ST_IDLE;
        end
      end
      default: begin
        nxt_st = st_ff;
      end
    endcase
    // request falling aborts the sequence; alarms follow if present and an absolute encoder is set
    if (!absolute_data_request_i && req_d_ff) begin
      nxt_idx = 3'h0;
      nxt_st = (absolute_encoder_i && alarm_active_i) ? ST_ALARM : ST_IDLE;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      st_ff <= ST_IDLE;
      tmr_ff <= '0;
      mag_ff <= '0;
      dig_ff <= 4'h0;
      idx_ff <= 3'h0;
      neg_ff <= 1'b0;
      init_left_ff <= 18'h00000;
      req_d_ff <= 1'b0;
    end else begin
      st_ff <= nxt_st;
      tmr_ff <= nxt_tmr;
      mag_ff <= nxt_mag;
      dig_ff <= nxt_dig;
      idx_ff <= nxt_idx;
      neg_ff <= nxt_neg;
      init_left_ff <= nxt_init_left;
      req_d_ff <= absolute_data_request_i;
    end
  end

  // ----------------------------------------------------------------
  // character fifo and serial transmitter
  // ----------------------------------------------------------------
  logic tx_pop;
  logic [9:0] tx_sh_ff, nxt_tx_sh;
  logic [3:0] tx_bits_ff, nxt_tx_bits;
  logic [12:0] tx_cnt_ff, nxt_tx_cnt;
  logic nxt_tx_busy;

  assign tx_pop = !tx_busy_ff && fifo_out_valid;

  apso_fifo #(
    .WIDTH(`APSO_CHAR_W),
    .DEPTH(`APSO_FIFO_DEPTH)
  ) u_fifo (
    .clk_i(clk_i),
    .resetn_i(resetn_i),
    .in_valid_i(push_valid),
    .in_ready_o(fifo_in_ready),
    .in_data_i(push_data),
    .out_valid_o(fifo_out_valid),
    .out_ready_i(!tx_busy_ff),
    .out_data_o(fifo_out_data)
  );

  always_comb begin
    nxt_tx_sh = tx_sh_ff;
    nxt_tx_bits = tx_bits_ff;
    nxt_tx_cnt = tx_cnt_ff;
    nxt_tx_busy = tx_busy_ff;
    if (tx_pop) begin
      // stop, even parity, data LSB first, start
      nxt_tx_sh = {1'b1, ^fifo_out_data, fifo_out_data, 1'b0};
      nxt_tx_bits = `APSO_FRAME_BITS;
      nxt_tx_cnt = 13'(BIT_CYC_P - 1);
      nxt_tx_busy = 1'b1;
    end else if (tx_busy_ff) begin
      if (tx_cnt_ff == 13'h0000) begin
        nxt_tx_sh = {1'b1, tx_sh_ff[9:1]};
        nxt_tx_bits = tx_bits_ff - 4'h1;
        nxt_tx_cnt = 13'(BIT_CYC_P - 1);
        nxt_tx_busy = (tx_bits_ff != 4'h1);
      end else begin
        nxt_tx_cnt = tx_cnt_ff - 13'h0001;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      tx_sh_ff <= 10'h3FF;
      tx_bits_ff <= 4'h0;
      tx_cnt_ff <= 13'h0000;
      tx_busy_ff <= 1'b0;
    end else begin
      tx_sh_ff <= nxt_tx_sh;
      tx_bits_ff <= nxt_tx_bits;
      tx_cnt_ff <= nxt_tx_cnt;
      tx_busy_ff <= nxt_tx_busy;
    end
  end

  // ----------------------------------------------------------------
  // initial pulse rate, output divider and quadrature
  // ----------------------------------------------------------------
  logic [15:0] nco_ff, nxt_nco;
  logic [15:0] nco_inc;
  logic [2:0] den_shift;
  logic [18:0] div_ff, nxt_div;
  logic [18:0] div_sum;
  logic [1:0] quad_ff, nxt_quad;
  logic step_in, step_fwd, div_out;
  logic nxt_pa, nxt_pb, nxt_serial;

  // nco emits encoder counts at 680k * ENC_RES / denominator; the divider scales them back
  always_comb begin
    if (output_pulse_divider_setting_i <= 18'h04000) begin
      den_shift = 3'h4;
    end else if (output_pulse_divider_setting_i <= 18'h08000) begin
      den_shift = 3'h3;
    end else if (output_pulse_divider_setting_i <= 18'h10000) begin
      den_shift = 3'h2;
    end else if (output_pulse_divider_setting_i <= 18'h20000) begin
      den_shift = 3'h1;
    end else begin
      den_shift = 3'h0;
    end
    nco_inc = `APSO_INIT_RATE_KPPS << den_shift;
    nco_tick = (st_ff == ST_INIT) && ({1'b0, nco_ff} + {1'b0, nco_inc} >= 17'(`APSO_CLK_KHZ));
    nxt_nco = '0;
    if (st_ff == ST_INIT) begin
      nxt_nco = nco_tick ? 16'({1'b0, nco_ff} + {1'b0, nco_inc} - 17'(`APSO_CLK_KHZ)) : nco_ff + nco_inc;
    end
    step_in = 1'b0;
    step_fwd = 1'b1;
    if (st_ff == ST_INIT) begin
      step_in = nco_tick && (init_left_ff != 18'h00000);
    end else if ((st_ff == ST_NORM) || (st_ff == ST_IDLE)) begin
      step_in = enc_step_i;
      step_fwd = enc_fwd_i;
    end
    div_sum = div_ff + {1'b0, output_pulse_divider_setting_i};
    div_out = step_in && (div_sum >= 19'(ENC_RES_P));
    nxt_div = div_ff;
    if (clr_pulse) begin
      nxt_div = '0;
    end else if (step_in) begin
      nxt_div = div_out ? div_sum - 19'(ENC_RES_P) : div_sum;
    end
    nxt_quad = quad_ff;
    if (clr_pulse) begin
      nxt_quad = 2'h0;
    end else if (div_out) begin
      nxt_quad = step_fwd ? quad_ff + 2'h1 : quad_ff - 2'h1;
    end
    nxt_serial = (st_ff != ST_IDLE) && (st_ff != ST_INIT) && (st_ff != ST_NORM);
    // gray walk 00,01,11,10 on (a,b): b leads a going forward
    nxt_pb = quad_ff[0] ^ quad_ff[1];
    nxt_pa = nxt_serial ? (!tx_busy_ff || tx_sh_ff[0]) : quad_ff[1];
  end

  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      nco_ff <= '0;
      div_ff <= '0;
      quad_ff <= 2'h0;
      phase_a_output_o <= 1'b0;
      phase_b_output_o <= 1'b0;
      serial_active_o <= 1'b0;
      multiturn_limit_mismatch_alarm_o <= 1'b0;
      revolution_count_o <= 16'h0000;
    end else begin
      nco_ff <= nxt_nco;
      div_ff <= nxt_div;
      quad_ff <= nxt_quad;
      phase_a_output_o <= nxt_pa;
      phase_b_output_o <= nxt_pb;
      serial_active_o <= nxt_serial;
      multiturn_limit_mismatch_alarm_o <= nxt_alarm;
      revolution_count_o <= nxt_rev;
    end
  end
endmodule : apso_top

`default_nettype wire

/* File: apso_regs.svh */
`ifndef APSO_REGS_SVH
`define APSO_REGS_SVH

// ----------------------------------------------------------------
// clock and timing
// ----------------------------------------------------------------
`define APSO_CLK_HZ 50000000
`define APSO_CLK_KHZ 50000
`define APSO_BAUD_BPS 9600
`define APSO_BIT_CYC (`APSO_CLK_HZ / `APSO_BAUD_BPS)
`define APSO_REQ_WAIT_MS 100
`define APSO_REQ_WAIT_CYC (`APSO_CLK_HZ / 1000 * `APSO_REQ_WAIT_MS)
`define APSO_NORM_WAIT_MS 400
`define APSO_NORM_WAIT_CYC (`APSO_CLK_HZ / 1000 * `APSO_NORM_WAIT_MS)

// ----------------------------------------------------------------
// serial frame and characters
// ----------------------------------------------------------------
`define APSO_CHAR_W 7
`define APSO_FRAME_BITS 4'hA
`define APSO_MSG_DIGITS 3'h5
`define APSO_ALM_CHARS 3'h7
`define APSO_CH_P 7'h50
`define APSO_CH_PLUS 7'h2B
`define APSO_CH_MINUS 7'h2D
`define APSO_CH_ZERO 7'h30
`define APSO_CH_HEXA 7'h37
`define APSO_CH_CR 7'h0D
`define APSO_CH_A 7'h41
`define APSO_CH_L 7'h4C
`define APSO_CH_M 7'h4D
`define APSO_POW0 17'h02710
`define APSO_POW1 17'h003E8
`define APSO_POW2 17'h00064
`define APSO_POW3 17'h0000A
`define APSO_POW4 17'h00001

// ----------------------------------------------------------------
// pulse generation and multiturn
// ----------------------------------------------------------------
`define APSO_INIT_RATE_KPPS 16'h02A8
`define APSO_ENC_RES 262144
`define APSO_DEN_EXP_MAX 18
`define APSO_LIMIT_DEFAULT 16'hFFFF
`define APSO_FIFO_DEPTH 16

`endif

/* File: apso_pkg.sv */
package apso_pkg;
  typedef enum logic [3:0] {
    ST_IDLE   = 4'h0,
    ST_WAIT   = 4'h1,
    ST_HEAD   = 4'h3,
    ST_SIGN   = 4'h2,
    ST_DIGIT  = 4'h6,
    ST_CR     = 4'h7,
    ST_DRAIN  = 4'h5,
    ST_INIT   = 4'h4,
    ST_NORM   = 4'hC,
    ST_ALARM  = 4'hD,
    ST_ADRAIN = 4'hF
  } apso_state_e;
endpackage : apso_pkg

/* File: apso_top_sva.sv */
`timescale 1ns/100ps
`default_nettype none
// ------------------------------------------------------------
// port checker
// ------------------------------------------------------------
module apso_top_sva #(
  parameter int REQ_WAIT_P = 50
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic resetn_i,
  // inputs watched
  input wire logic absolute_data_request_i,
  input wire logic enc_fwd_i,
  input wire logic rev_step_i,
  input wire logic rev_fwd_i,
  input wire logic absolute_encoder_i,
  input wire logic single_turn_i,
  input wire logic [15:0] multiturn_limit_setting_i,
  input wire logic [15:0] encoder_multiturn_limit_i,
  input wire logic alarm_active_i,
  // outputs watched
  input wire logic phase_a_output_o,
  input wire logic phase_b_output_o,
  input wire logic multiturn_limit_mismatch_alarm_o,
  input wire logic serial_active_o,
  input wire logic [15:0] revolution_count_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!resetn_i);
  logic [1:0] age_ff;
  logic req_q_ff;
  int since_ff;
  // the limit is captured after release, so young cycles are not judged
  always_ff @(posedge clk_i) begin
    req_q_ff <= absolute_data_request_i;
    if (!resetn_i) begin
      age_ff <= 2'h0;
      since_ff <= REQ_WAIT_P;
    end else begin
      age_ff <= (age_ff == 2'h3) ? age_ff : age_ff + 2'h1;
      if (absolute_data_request_i && !req_q_ff && !serial_active_o) begin
        since_ff <= 0;
      end else if (since_ff < REQ_WAIT_P) begin
        since_ff <= since_ff + 1;
      end
    end
  end
  a_mismatch_alarm: assert property (
    age_ff == 2'h3 && $stable(encoder_multiturn_limit_i) |=> multiturn_limit_mismatch_alarm_o
      == ($past(absolute_encoder_i) && multiturn_limit_setting_i != $past(encoder_multiturn_limit_i)))
    else $error("mismatch alarm does not follow limit comparison");
  a_single_turn: assert property (
    age_ff == 2'h3 && single_turn_i && $past(single_turn_i) |-> revolution_count_o == 16'h0000)
    else $error("single turn count not zero");
  a_rev_default: assert property (
    age_ff == 2'h3 && rev_step_i && !single_turn_i
      && (multiturn_limit_setting_i == 16'hFFFF || !absolute_encoder_i)
    |=> revolution_count_o == $past(revolution_count_o) + ($past(rev_fwd_i) ? 16'h0001 : 16'hFFFF))
    else $error("default revolution count step wrong");
  a_limit_wrap: assert property (
    age_ff == 2'h3 && rev_step_i && !single_turn_i && absolute_encoder_i
      && multiturn_limit_setting_i != 16'hFFFF
      && revolution_count_o == (rev_fwd_i ? multiturn_limit_setting_i : 16'h0000)
    |=> revolution_count_o == ($past(rev_fwd_i) ? 16'h0000 : multiturn_limit_setting_i))
    else $error("multiturn limit wrap wrong");
  a_wait_quiet: assert property (
    absolute_data_request_i && serial_active_o && $past(serial_active_o) && since_ff < REQ_WAIT_P
    |-> phase_a_output_o)
    else $error("serial line active during request wait");
  a_quad_gray: assert property (
    (!serial_active_o) [*3] |-> !($changed(phase_a_output_o) && $changed(phase_b_output_o)))
    else $error("both quadrature phases moved together");
  a_b_leads: assert property (
    (!serial_active_o) [*3] ##0 $rose(phase_a_output_o) |-> phase_b_output_o == $past(enc_fwd_i, 4))
    else $error("phase order does not match direction");
  a_alarm_start: assert property (
    $fell(absolute_data_request_i) && absolute_encoder_i && alarm_active_i && since_ff < REQ_WAIT_P
    |-> ##[2:8] (serial_active_o && !phase_a_output_o))
    else $error("alarm transfer did not start");
endmodule : apso_top_sva

bind apso_top apso_top_sva #(.REQ_WAIT_P(REQ_WAIT_P)) u_apso_sva (
  .clk_i(clk_i),
  .resetn_i(resetn_i),
  .absolute_data_request_i(absolute_data_request_i),
  .enc_fwd_i(enc_fwd_i),
  .rev_step_i(rev_step_i),
  .rev_fwd_i(rev_fwd_i),
  .absolute_encoder_i(absolute_encoder_i),
  .single_turn_i(single_turn_i),
  .multiturn_limit_setting_i(multiturn_limit_setting_i),
  .encoder_multiturn_limit_i(encoder_multiturn_limit_i),
  .alarm_active_i(alarm_active_i),
  .phase_a_output_o(phase_a_output_o),
  .phase_b_output_o(phase_b_output_o),
  .multiturn_limit_mismatch_alarm_o(multiturn_limit_mismatch_alarm_o),
  .serial_active_o(serial_active_o),
  .revolution_count_o(revolution_count_o)
);
`default_nettype wire

/* File: apso_host_model.sv */
`timescale 1ns/100ps
`default_nettype none
// ------------------------------------------------------------
// host: serial receiver and quadrature counter
// ------------------------------------------------------------
module apso_host_model #(
  parameter int BIT_CYC_P = 8
) (
  // clock
  input wire logic clk_i,
  // device pins
  input wire logic phase_a_i,
  input wire logic phase_b_i,
  input wire logic serial_active_i,
  // host side
  input wire logic clr_i,
  output logic rx_valid_o,
  output logic [7:0] rx_char_o,
  output logic signed [31:0] pulse_cnt_o
);
  logic [7:0] sh;
  logic ok;
  logic last;
  logic ser_q;
  logic [1:0] idx_q;
  logic [1:0] dlt;
  initial begin
    rx_valid_o = 1'b0;
    rx_char_o = 8'h00;
    pulse_cnt_o = 0;
    last = 1'b1;
  end
  // bit 7 of the char reports start, parity and stop all good
  always begin
    @(posedge clk_i);
    rx_valid_o <= 1'b0;
    if (serial_active_i && last && !phase_a_i) begin
      repeat (BIT_CYC_P / 2) @(posedge clk_i);
      ok = !phase_a_i;
      for (int i = 0; i < 8; i++) begin
        repeat (BIT_CYC_P) @(posedge clk_i);
        sh[i] = phase_a_i;
      end
      repeat (BIT_CYC_P) @(posedge clk_i);
      ok = ok && phase_a_i && !(^sh);
      rx_char_o <= {ok, sh[6:0]};
      rx_valid_o <= 1'b1;
    end
    last = phase_a_i;
  end
  // host builds position as revolutions times pulses per rev plus this count
  assign dlt = {phase_a_i, phase_a_i ^ phase_b_i} - idx_q;
  always @(posedge clk_i) begin
    idx_q <= {phase_a_i, phase_a_i ^ phase_b_i};
    ser_q <= serial_active_i;
    if (clr_i) begin
      pulse_cnt_o <= 0;
    end else if (!serial_active_i && !ser_q) begin
      if (dlt == 2'h1) begin
        pulse_cnt_o <= pulse_cnt_o + 1;
      end else if (dlt == 2'h3) begin
        pulse_cnt_o <= pulse_cnt_o - 1;
      end
    end
  end
endmodule : apso_host_model
`default_nettype wire

/* File: test_absolute_position_serial_output.sv */
`timescale 1ns/100ps
`default_nettype none
// ------------------------------------------------------------
// testbench
// ------------------------------------------------------------
module test_absolute_position_serial_output;
  logic clk_i = 1'b0;
  logic resetn_i = 1'b0;
  logic req = 1'b0;
  logic est = 1'b0;
  logic efwd = 1'b1;
  logic rst = 1'b0;
  logic rfwd = 1'b1;
  logic st = 1'b0;
  logic [15:0] lim = 16'hFFFF;
  logic [15:0] elim = 16'hFFFF;
  logic alm = 1'b0;
  logic abse = 1'b1;
  logic [17:0] ipc = 18'h000A0;
  logic [11:0] acode = 12'hA5C;
  logic pa, pb, mm, sa, clr, rxv, neg;
  logic [15:0] rcnt;
  logic [7:0] rxc, c;
  logic signed [31:0] pcnt;
  logic [7:0] rxq [$];
  logic [6:0] em [8];
  int n_fail = 0;
  int num_checks = 0;
  int mag, t;
  // rows: limit, encoder limit, single turn, steps, direction, count
  logic [15:0] r_lim [7] = '{16'hFFFF, 16'hFFFF, 16'hFFFF, 16'h0063, 16'h0063, 16'hFFFF, 16'hFFFF};
  logic [15:0] r_enc [7] = '{16'hFFFF, 16'hFFFF, 16'h0000, 16'h0063, 16'h0063, 16'hFFFF, 16'hFFFF};
  logic r_st [7] = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0};
  int r_n [7] = '{3, 2, 0, 1, 100, 5, 32769};
  logic r_fwd [7] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b1, 1'b0};
  logic [15:0] r_exp [7] = '{16'h0003, 16'hFFFE, 16'h0000, 16'h0063, 16'h0000, 16'h0000, 16'h7FFF};
  logic [6:0] al [7] = '{7'h41, 7'h4C, 7'h4D, 7'h41, 7'h35, 7'h43, 7'h0D};

  always #10 clk_i = !clk_i;

  apso_top #(.BIT_CYC_P(8), .REQ_WAIT_P(50), .NORM_WAIT_P(200)) uut (
    .clk_i(clk_i),
    .resetn_i(resetn_i),
    .absolute_data_request_i(req),
    .enc_step_i(est),
    .enc_fwd_i(efwd),
    .rev_step_i(rst),
    .rev_fwd_i(rfwd),
    .init_pulse_count_i(ipc),
    .absolute_encoder_i(abse),
    .single_turn_i(st),
    .output_pulse_divider_setting_i(18'h04000),
    .multiturn_limit_setting_i(lim),
    .encoder_multiturn_limit_i(elim),
    .alarm_active_i(alm),
    .alarm_code_i(acode),
    .phase_a_output_o(pa),
    .phase_b_output_o(pb),
    .multiturn_limit_mismatch_alarm_o(mm),
    .serial_active_o(sa),
    .revolution_count_o(rcnt)
  );

  apso_host_model #(.BIT_CYC_P(8)) u_host (
    .clk_i(clk_i),
    .phase_a_i(pa),
    .phase_b_i(pb),
    .serial_active_i(sa),
    .clr_i(clr),
    .rx_valid_o(rxv),
    .rx_char_o(rxc),
    .pulse_cnt_o(pcnt)
  );

  always @(posedge clk_i) begin
    if (rxv) begin
      rxq.push_back(rxc);
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic final_report;
    $display("checks=%0d mismatches=%0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : final_report

  task automatic cyc(input int n);
    repeat (n) @(negedge clk_i);
  endtask : cyc

  task automatic do_reset;
    resetn_i = 1'b0;
    cyc(8);
    chk({pa, pb, mm, sa, rcnt}, 32'h0);
    rxq.delete();
    resetn_i = 1'b1;
    cyc(2);
  endtask : do_reset

  task automatic steps(input int n, input logic fwd, input logic enc);
    rfwd = fwd;
    efwd = fwd;
    repeat (n) begin
      @(negedge clk_i);
      rst = !enc;
      est = enc;
      @(negedge clk_i);
      rst = 1'b0;
      est = 1'b0;
    end
    efwd = 1'b1;
  endtask : steps

  task automatic get_char(output logic [7:0] ch);
    int k;
    k = 0;
    while (rxq.size() == 0 && k < 2000) begin
      @(negedge clk_i);
      k++;
    end
    if (rxq.size() == 0) begin
      n_fail++;
      final_report();
    end
    ch = rxq.pop_front();
  endtask : get_char

  task automatic wait_pc(input int v, output int n);
    n = 0;
    while (pcnt !== v && n < 3000) begin
      @(negedge clk_i);
      n++;
    end
    if (pcnt !== v) begin
      n_fail++;
      final_report();
    end
  endtask : wait_pc

  function automatic logic [6:0] dig(input int m, input int p);
    return 7'h30 + 7'((m / p) % 10);
  endfunction : dig

  initial begin
    clr = 1'b0;
    for (int r = 0; r < 7; r++) begin
      lim = r_lim[r];
      elim = r_enc[r];
      st = r_st[r];
      do_reset();
      steps(r_n[r], r_fwd[r], 1'b0);
      cyc(2);
      chk(rcnt, r_exp[r]);
      chk(mm, r_lim[r] != r_enc[r]);
      neg = (r_lim[r] == 16'hFFFF) && r_exp[r][15];
      mag = neg ? 65536 - int'(r_exp[r]) : int'(r_exp[r]);
      em = '{7'h50, neg ? 7'h2D : 7'h2B, dig(mag, 10000), dig(mag, 1000), dig(mag, 100), dig(mag, 10),
             dig(mag, 1), 7'h0D};
      req = 1'b1;
      clr = 1'b1;
      cyc(1);
      clr = 1'b0;
      for (int i = 0; i < 8; i++) begin
        get_char(c);
        chk(c, {1'b1, em[i]});
      end
      // ten divided initial pulses, about 73.5 clocks apart at this setting
      wait_pc(1, t);
      wait_pc(10, t);
      chk(t >= 649 && t <= 673, 1);
      cyc(250);
      steps(32, r_fwd[r], 1'b1);
      cyc(8);
      chk(pcnt, r_fwd[r] ? 12 : 8);
      req = 1'b0;
      cyc(4);
    end
    alm = 1'b1;
    req = 1'b1;
    cyc(20);
    // motor power is taken off before the request drops
    req = 1'b0;
    for (int i = 0; i < 7; i++) begin
      get_char(c);
      chk(c, {1'b1, al[i]});
    end
    // no absolute encoder: the limit is ignored and a falling request sends nothing
    abse = 1'b0;
    lim = 16'h0063;
    do_reset();
    chk(mm, 1'b0);
    req = 1'b1;
    cyc(20);
    req = 1'b0;
    cyc(200);
    chk(rxq.size(), 0);
    final_report();
  end
endmodule : test_absolute_position_serial_output
`default_nettype wire
